// file: tbs_scheduler.sv
// transmit buffer scheduler: commit, arbitration, send and flag update
`timescale 1ns/1ps
// Functional notes
// - payload only from configured committed transmit buffers
// - commit then unlock makes buffer eligible
// - static segment picks identifier equal slot
// - only valid buffers are transmitted
// - static tie goes to lowest buffer
// - same static slot, both channels together
// - committed buffer turns valid, lock refused
// - after send set event, clear commit
// - dynamic segment picks lowest frame identifier
// - channels share one dynamic minislot sequence
// - no dynamic frame overlapping idle window
// - dynamic tie losers withheld until next cycle
// - never null frames in dynamic segment
// - same dynamic slot, same minislot both channels
// - transmit only if buffer or sync configured
// - double buffer transmit config copied to odd partner
// - null frames leave buffer flags unchanged
// - identifier zero buffers are ignored
module tbs_scheduler (
    input wire logic ref_clk_i,                                  // 40 MHz clock
    input wire logic reset_n_i,                                  // synchronous reset, low
    // per buffer configuration and host handshake
    input wire logic [tbs_pkg::NUM_BUF-1:0] cfg_tx_i,            // buffer is transmit
    input wire logic [tbs_pkg::NUM_BUF-1:0] cfg_type_i,          // buffer_type_bit, 1 double
    input wire logic [tbs_pkg::NUM_BUF-1:0] cfg_kind_i,          // transmit_kind_bit, 1 keeps valid
    input wire logic [tbs_pkg::NUM_BUF-1:0] cfg_ch_a_i,          // buffer uses channel a
    input wire logic [tbs_pkg::NUM_BUF*tbs_pkg::FID_W-1:0] cfg_fid_i, // frame ids packed
    input wire logic [tbs_pkg::NUM_BUF-1:0] lock_req_i,          // host lock request pulse
    input wire logic [tbs_pkg::NUM_BUF-1:0] unlock_req_i,        // host unlock request pulse
    input wire logic [tbs_pkg::NUM_BUF-1:0] commit_i,            // host writes 1 to commit
    input wire logic [tbs_pkg::NUM_BUF-1:0] event_clr_i,         // host clears event flag
    input wire logic [tbs_pkg::SYNC_W-1:0] sync_frame_config_reg_i, // sync frame config
    input wire logic [tbs_pkg::IDLE_W-1:0] idle_window_config_reg_i, // idle window start
    // protocol timing
    input wire logic cycle_start_i,                              // new communication cycle pulse
    input wire logic slot_start_i,                               // slot start pulse
    input wire logic dyn_seg_i,                                  // 1 in dynamic segment
    input wire logic null_frame_i,                               // static slot sent as null frame
    input wire logic [tbs_pkg::FID_W-1:0] slot_id_i,             // next sending slot
    input wire logic [tbs_pkg::IDLE_W-1:0] now_mt_i,             // current time in cycle
    input wire logic [tbs_pkg::WORDS_W-1:0] frame_len_i,         // words of picked frame
    input wire logic [tbs_pkg::DATA_W-1:0] buf_data_i,           // word from buffer memory
    // line side
    input wire logic line_ready_i,                               // coder takes a word
    output logic [tbs_pkg::BUF_IDX_W-1:0] rd_buf_o,              // buffer being read
    output logic [1:0] tx_ch_o,                                  // channels in use
    output logic tx_active_o,                                    // frame in progress
    output logic [tbs_pkg::DATA_W-1:0] tx_data_o,                // word to coder
    output logic tx_valid_o,                                     // word valid
    output logic tx_enable_o,                                    // node may transmit
    output logic [tbs_pkg::NUM_BUF-1:0] lock_ack_o,              // host lock granted
    output logic [tbs_pkg::NUM_BUF-1:0] commit_flag_o,           // commit_flag per buffer
    output logic [tbs_pkg::NUM_BUF-1:0] valid_o,                 // valid per buffer
    output logic [tbs_pkg::NUM_BUF-1:0] buffer_event_flag_o      // buffer_event_flag per buffer
);
    import tbs_pkg::*;
    // ************************************************************
    // per buffer state
    // ************************************************************
    logic [NUM_BUF-1:0] locked;      // host holds the buffer
    logic [NUM_BUF-1:0] commit;      // committed, not yet sent
    logic [NUM_BUF-1:0] valid;       // eligible for sending
    logic [NUM_BUF-1:0] evflag;      // sent event
    logic [NUM_BUF-1:0] withheld;    // lost a dynamic tie this cycle
    logic [NUM_BUF-1:0] sent;        // one-hot buffer finished this cycle
    logic [NUM_BUF-1:0] cand;        // buffers that qualify now
    logic [FID_W-1:0] fid [NUM_BUF]; // unpacked identifiers
    logic [NUM_BUF-1:0] cfg_eff_tx;  // transmit config incl. double partner
    tbs_state_t state;
    tbs_state_t next_state;
    logic [BUF_IDX_W-1:0] cur;       // picked buffer
    logic [WORDS_W-1:0] left;        // words still to fetch
    tbs_fifo_if fq ();
    // ************************************************************
    // per buffer qualification
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_BUF; g++)
        begin : gen_buf
            assign fid[g] = cfg_fid_i[g*FID_W +: FID_W];
            // odd partner of a double pair inherits the host side transmit config
            if (g % 2 == 1)
            begin : gen_odd
                assign cfg_eff_tx[g] = cfg_tx_i[g] | (cfg_tx_i[g-1] & cfg_type_i[g-1]);
            end
            else
            begin : gen_even
                assign cfg_eff_tx[g] = cfg_tx_i[g];
            end
            // qualifies: transmit, id nonzero, valid, committed, unlocked
            assign cand[g] = cfg_eff_tx[g] && (fid[g] != FID_NONE)
                && valid[g] && commit[g] && !locked[g]
                && !withheld[g]
                && (dyn_seg_i || fid[g] == slot_id_i);
        end
    endgenerate
    // ************************************************************
    // arbitration
    // ************************************************************
    logic [BUF_IDX_W-1:0] win;   // winning buffer
    logic win_any;               // any candidate
    logic [FID_W-1:0] win_fid;   // winner id
    // lowest id wins, strict less-than keeps the lowest index on ties
    always_comb
    begin
        win = '0;
        win_any = 1'b0;
        win_fid = '1;
        for (int i = 0; i < NUM_BUF; i++)
        begin
            if (cand[i] && (!win_any || fid[i] < win_fid))
            begin
                win = BUF_IDX_W'(i);
                win_any = 1'b1;
                win_fid = fid[i];
            end
        end
    end
    // both channels of same id go in the same slot, so channel set merges
    logic [1:0] win_ch;          // channels used by every same-id buffer
    logic [NUM_BUF-1:0] same_id; // other candidates sharing winner id
    always_comb
    begin
        win_ch = 2'h0;
        same_id = '0;
        for (int i = 0; i < NUM_BUF; i++)
        begin
            if (cand[i] && fid[i] == win_fid)
            begin
                win_ch = win_ch | (cfg_ch_a_i[i] ? CH_A : CH_B);
                if (BUF_IDX_W'(i) != win)
                    same_id[i] = 1'b1;
            end
        end
    end
    // idle window guard: in the dynamic segment, frame end must fall before window start
    wire [IDLE_W:0] end_mt = {1'b0, now_mt_i} + {{(IDLE_W+1-WORDS_W){1'b0}}, frame_len_i};
    wire window_ok = !dyn_seg_i || (end_mt < {1'b0, idle_window_config_reg_i});
    wire node_on = (|cfg_eff_tx) || (sync_frame_config_reg_i != SYNC_NONE);
    // no null frames in dynamic part: only start when a buffer wins
    wire go = slot_start_i && win_any && window_ok && node_on && !null_frame_i;
    wire last_fetch = (left == '0);
    wire fetch = (state == ST_SEND) && !last_fetch && fq.wr_ready; // fifo back-pressure stalls
    assign fq.wr_data = buf_data_i;
    assign fq.wr_valid = fetch;
    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE: if (go) next_state = ST_SEND;
            ST_SEND: if (last_fetch) next_state = ST_DONE;
            ST_DONE: if (!fq.rd_valid && !tx_valid_o) next_state = ST_IDLE;
            ST_PICK: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end
    // state, picked buffer, word count
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            state <= ST_IDLE;
            cur <= '0;
            left <= '0;
            tx_ch_o <= 2'h0;
        end
        else
        begin
            state <= next_state;
            if (state == ST_IDLE && go)
            begin
                cur <= win;
                left <= frame_len_i;
                tx_ch_o <= win_ch;
            end
            else if (fetch)
                left <= WORDS_W'(left - 1'b1);
        end
    end
    assign sent = (state == ST_DONE && next_state == ST_IDLE) ? (NUM_BUF'(1) << cur) : '0;
    // ************************************************************
    // flag update
    // ************************************************************
    logic [NUM_BUF-1:0] unlock_go; // unlock that hands over a committed buffer
    assign unlock_go = unlock_req_i & locked & commit_i;
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            locked <= '0;
            commit <= '0;
            valid <= '0;
            evflag <= '0;
            withheld <= '0;
        end
        else
        begin
            // lock refused while committed and unsent
            locked <= (locked | (lock_req_i & ~commit & cfg_eff_tx)) & ~unlock_req_i;
            // commit on unlock; sending clears it unless a new commit lands
            commit <= (commit & ~sent) | unlock_go;
            // valid: set by commit, after send kept only when kind bit set
            valid <= (valid & ~(sent & ~cfg_kind_i)) | unlock_go;
            // event flag set wins over clear
            evflag <= (evflag & ~event_clr_i) | sent;
            if (cycle_start_i)
                withheld <= '0;
            else if (state == ST_IDLE && go && dyn_seg_i)
                withheld <= withheld | same_id;
        end
    end
    // ************************************************************
    // payload fifo and line output
    // ************************************************************
    tbs_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .f(fq)
    );
    assign fq.rd_ready = !tx_valid_o || line_ready_i;
    // registered output stage; coder stalls by holding line_ready_i low
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            tx_data_o <= '0;
            tx_valid_o <= 1'b0;
            rd_buf_o <= '0;
            tx_active_o <= 1'b0;
            tx_enable_o <= 1'b0;
            lock_ack_o <= '0;
            commit_flag_o <= '0;
            valid_o <= '0;
            buffer_event_flag_o <= '0;
        end
        else
        begin
            if (fq.rd_ready)
            begin
                tx_data_o <= fq.rd_data;
                tx_valid_o <= fq.rd_valid;
            end
            rd_buf_o <= (state == ST_IDLE) ? win : cur;
            tx_active_o <= (next_state != ST_IDLE);
            tx_enable_o <= node_on;
            lock_ack_o <= locked;
            commit_flag_o <= commit;
            valid_o <= valid;
            buffer_event_flag_o <= evflag;
        end
    end
    // ************************************************************
    // checks
    // ************************************************************
    AST_START_VALID: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == ST_IDLE && go) |-> valid[win] && commit[win])
        else $error("frame started from a buffer not valid and committed");
    AST_STATIC_ID: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == ST_IDLE && go && !dyn_seg_i) |-> fid[win] == slot_id_i)
        else $error("static frame id differs from slot");
    AST_NONZERO_ID: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == ST_IDLE && go) |-> fid[win] != FID_NONE)
        else $error("buffer with identifier zero picked");
    logic [NUM_BUF-1:0] sent_q;  // helper: last sent buffer
    logic [NUM_BUF-1:0] commit_q2; // helper: recommitted together with send
    AST_SENT_FLAGS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (|sent) |=> ((evflag & sent_q) == sent_q) && ((commit & sent_q & ~commit_q2) == '0))
        else $error("flags not updated after send");
    always_ff @(posedge ref_clk_i)
    begin
        sent_q <= sent;
        commit_q2 <= unlock_go;
    end
    AST_LOCK_REFUSED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (commit[2] && !locked[2] && !unlock_req_i[2]) |=> !locked[2])
        else $error("committed buffer became locked");
    AST_IDLE_WINDOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == ST_IDLE && go && dyn_seg_i) |-> end_mt < {1'b0, idle_window_config_reg_i})
        else $error("dynamic frame overlaps idle window");
    AST_NO_NULL: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (slot_start_i && !win_any && state == ST_IDLE) |=> state == ST_IDLE)
        else $error("frame started without a winning buffer");
    AST_NODE_OFF: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (!node_on && state == ST_IDLE) |=> state == ST_IDLE)
        else $error("transmission with no buffer and no sync frame");
    AST_LOWEST: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == ST_IDLE && go && cand[0] && fid[0] == win_fid) |-> win == '0)
        else $error("tie not won by lowest buffer");
endmodule

// file: tbs_pkg.sv
// package of constants and types for the transmit buffer scheduler
package tbs_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_BUF = 8;              // number of transmit buffers
    localparam int BUF_IDX_W = 3;            // buffer index width
    localparam int FID_W = 11;               // frame identifier width
    localparam int DATA_W = 16;              // payload word width
    localparam int FIFO_DEPTH = 16;          // payload fifo depth
    localparam int SYNC_W = 16;              // sync frame config width
    localparam int IDLE_W = 16;              // idle window config width
    localparam int WORDS_W = 8;              // frame length in words
    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [FID_W-1:0] FID_NONE = 11'h000;     // identifier 0 means unused
    localparam logic [SYNC_W-1:0] SYNC_NONE = 16'h0000;  // no sync frame configured
    localparam logic [1:0] CH_A = 2'h1;                  // channel a bit
    localparam logic [1:0] CH_B = 2'h2;                  // channel b bit
    // ************************************************************
    // scheduler states
    // ************************************************************
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_PICK = 4'h2,
        ST_SEND = 4'h4,
        ST_DONE = 4'h8
    } tbs_state_t;
endpackage

// file: tbs_fifo_if.sv
// interface carrying payload words between scheduler and fifo
`timescale 1ns/1ps
interface tbs_fifo_if;
    import tbs_pkg::*;
    logic [DATA_W-1:0] wr_data; // word into fifo
    logic wr_valid;             // word offered
    logic wr_ready;             // fifo has room
    logic [DATA_W-1:0] rd_data; // word out of fifo
    logic rd_valid;             // fifo not empty
    logic rd_ready;             // drain side takes word
    modport fill (output wr_data, output wr_valid, input wr_ready);
    modport store (input wr_data, input wr_valid, output wr_ready,
                   output rd_data, output rd_valid, input rd_ready);
endinterface

// file: tbs_fifo.sv
// parameterised payload fifo with valid and ready on both sides
`timescale 1ns/1ps
module tbs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    tbs_fifo_if.store f
);
    import tbs_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];    // storage array
    logic [AW-1:0] wr_ptr;            // write pointer
    logic [AW-1:0] rd_ptr;            // read pointer
    logic [AW:0] count;               // fill level
    wire do_wr = f.wr_valid && f.wr_ready;
    wire do_rd = f.rd_valid && f.rd_ready;
    assign f.wr_ready = (count != (AW+1)'(DEPTH)); // honest full
    assign f.rd_valid = (count != '0);              // honest empty
    assign f.rd_data = mem[rd_ptr];
    // pointers and level; level moves by the difference of pushes and pops
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= AW'(wr_ptr + 1'b1);
            if (do_rd)
                rd_ptr <= AW'(rd_ptr + 1'b1);
            count <= (AW+1)'(count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd});
        end
    end
    // storage has no reset, data is qualified by the level
    always_ff @(posedge ref_clk_i)
    begin
        if (do_wr)
            mem[wr_ptr] <= f.wr_data;
    end
    AST_NO_OVERFLOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        count <= (AW+1)'(DEPTH))
        else $error("fifo level beyond its depth");
endmodule

// file: tbs_host.sv
// host model that locks, commits and unlocks transmit buffers
`timescale 1ns/1ps
module tbs_host (
    input wire logic ref_clk_i,
    input wire logic [tbs_pkg::NUM_BUF-1:0] lock_ack_i,
    output logic [tbs_pkg::NUM_BUF-1:0] lock_req_o,
    output logic [tbs_pkg::NUM_BUF-1:0] unlock_req_o,
    output logic [tbs_pkg::NUM_BUF-1:0] commit_o
);
    import tbs_pkg::*;
    // quiet host until asked
    initial
    begin
        lock_req_o = '0;
        unlock_req_o = '0;
        commit_o = '0;
    end
    // prepare one buffer; a refused lock leaves the buffer alone
    task automatic prep(input int idx, output bit granted);
        int n;
        granted = 1'b0;
        @(posedge ref_clk_i);
        lock_req_o[idx] <= 1'b1;
        @(posedge ref_clk_i);
        lock_req_o[idx] <= 1'b0;
        // never touch contents before the grant shows
        for (n = 0; n < 6 && !granted; n++)
        begin
            @(posedge ref_clk_i);
            granted = (lock_ack_i[idx] === 1'b1);
        end
        if (granted)
        begin
            commit_o[idx] <= 1'b1;
            unlock_req_o[idx] <= 1'b1;
            @(posedge ref_clk_i);
            commit_o[idx] <= 1'b0;
            unlock_req_o[idx] <= 1'b0;
        end
    endtask
endmodule

// file: tbs_scheduler_tb.sv
// self-checking bench of the transmit buffer scheduler
`timescale 1ns/1ps
module tbs_scheduler_tb;
    import tbs_pkg::*;
    // ************************************************************
    // stimulus, outputs and model state
    // ************************************************************
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] cfg_tx_i, cfg_type_i, cfg_kind_i, cfg_ch_a_i, lock_req_i, unlock_req_i, commit_i, event_clr_i;
    logic [87:0] cfg_fid_i;
    logic [15:0] sync_frame_config_reg_i, idle_window_config_reg_i, now_mt_i, buf_data_i, tx_data_o;
    logic cycle_start_i, slot_start_i, dyn_seg_i, null_frame_i, line_ready_i, tx_active_o, tx_valid_o, tx_enable_o;
    logic [10:0] slot_id_i;
    logic [7:0] frame_len_i, lock_ack_o, commit_flag_o, valid_o, buffer_event_flag_o;
    logic [2:0] rd_buf_o;
    logic [1:0] tx_ch_o;
    logic [7:0] mc = '0, mv = '0, me = '0, wh = '0; // model commit, valid, event, withheld
    logic [15:0] mem [8]; // buffer payload words
    logic [31:0] rnd = 32'h9b74;
    int fid [8] = '{5, 5, 3, 20, 20, 12, 0, 12}; // dynamic ids above static
    int errors = 0;
    int compares = 0;
    bit g;
    localparam logic [7:0] TXC = 8'h7f, KIND = 8'h0f, CHA = 8'h55;
    logic [7:0] mtx = TXC; // model transmit config incl. double partner
    always #12.5 ref_clk_i = ~ref_clk_i;
    assign buf_data_i = mem[rd_buf_o];
    tbs_scheduler uut (.ref_clk_i, .reset_n_i, .cfg_tx_i, .cfg_type_i, .cfg_kind_i, .cfg_ch_a_i, .cfg_fid_i,
        .lock_req_i, .unlock_req_i, .commit_i, .event_clr_i, .sync_frame_config_reg_i, .idle_window_config_reg_i,
        .cycle_start_i, .slot_start_i, .dyn_seg_i, .null_frame_i, .slot_id_i, .now_mt_i, .frame_len_i,
        .buf_data_i, .line_ready_i, .rd_buf_o, .tx_ch_o, .tx_active_o, .tx_data_o, .tx_valid_o, .tx_enable_o,
        .lock_ack_o, .commit_flag_o, .valid_o, .buffer_event_flag_o);
    tbs_host u_host (.ref_clk_i, .lock_ack_i(lock_ack_o), .lock_req_o(lock_req_i), .unlock_req_o(unlock_req_i),
        .commit_o(commit_i));
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // random stalls on the line side keep the fifo under pressure
    always @(posedge ref_clk_i)
    begin
        rnd <= lfsr(rnd);
        line_ready_i <= rnd[3] | rnd[7];
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // model winner: committed, valid, nonzero id, lowest id then lowest index
    function automatic int pick(input bit dyn, input int slot, output logic [1:0] chs);
        int w = -1;
        chs = 2'h0;
        for (int i = 0; i < NUM_BUF; i++)
            if (mtx[i] && mc[i] && mv[i] && fid[i] != 0 && !wh[i] && (dyn || fid[i] == slot) && (w < 0 || fid[i] < fid[w]))
                w = i;
        for (int i = 0; i < NUM_BUF && w >= 0; i++)
            if (mtx[i] && mc[i] && mv[i] && !wh[i] && fid[i] == fid[w])
                chs = chs | (CHA[i] ? CH_A : CH_B);
        return w;
    endfunction
    // one slot: start, observe winner and payload, then the flag update
    task automatic send(input bit dyn, input int slot, input int len, input logic [15:0] now, input bit nul);
        int w, got, n;
        logic [1:0] chs;
        w = pick(dyn, slot, chs);
        if (nul || (dyn && now + len >= 16'h0100))
            w = -1;
        @(posedge ref_clk_i);
        dyn_seg_i <= dyn;
        slot_id_i <= slot[10:0];
        frame_len_i <= len[7:0];
        now_mt_i <= now;
        null_frame_i <= nul;
        slot_start_i <= 1'b1;
        @(posedge ref_clk_i);
        slot_start_i <= 1'b0;
        @(negedge ref_clk_i);
        check("active", tx_active_o, w >= 0);
        got = 0;
        if (w >= 0)
        begin
            check("buffer", rd_buf_o, w[2:0]);
            check("channels", tx_ch_o, chs);
            for (n = 0; n < 400 && got < len; n++)
            begin
                @(negedge ref_clk_i);
                if (tx_valid_o === 1'b1 && line_ready_i)
                begin
                    check("word", tx_data_o, mem[w]);
                    got++;
                end
            end
            check("count", got, len);
            for (int i = 0; i < NUM_BUF && dyn; i++)
                wh[i] = wh[i] | (i != w && mc[i] && mv[i] && fid[i] == fid[w]);
            me[w] = 1'b1;
            mc[w] = 1'b0;
            mv[w] = KIND[w];
        end
        repeat (8) @(negedge ref_clk_i);
        check("flags", {commit_flag_o, valid_o}, {mc, mv});
        check("events", buffer_event_flag_o, me);
        check("idle", {tx_active_o, tx_valid_o}, 0);
    endtask
    // commit one buffer through the host model
    task automatic commit_buf(input int i);
        u_host.prep(i, g);
        check("grant", g, 1);
        mc[i] = 1'b1;
        mv[i] = 1'b1;
        repeat (3) @(negedge ref_clk_i); // commit settles long before the slot
        check("committed", {commit_flag_o, valid_o}, {mc, mv});
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        {cfg_tx_i, cfg_type_i, event_clr_i, cycle_start_i, slot_start_i, dyn_seg_i, null_frame_i} = '0;
        {slot_id_i, now_mt_i, frame_len_i, sync_frame_config_reg_i} = '0;
        cfg_type_i = 8'h00; // single buffers first
        cfg_kind_i = KIND;
        cfg_ch_a_i = CHA;
        idle_window_config_reg_i = 16'h0100;
        line_ready_i = 1'b1;
        for (int i = 0; i < NUM_BUF; i++)
        begin
            cfg_fid_i[i*11+:11] = fid[i][10:0];
            rnd = lfsr(rnd);
            mem[i] = rnd[15:0];
        end
        repeat (6) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(negedge ref_clk_i);
        check("reset", {commit_flag_o, valid_o, lock_ack_o, buffer_event_flag_o}, 0);
        for (int n = 0; n < 4; n++)
        begin
            @(posedge ref_clk_i);
            cfg_tx_i <= n[0] ? TXC : 8'h00;
            sync_frame_config_reg_i <= {15'h0000, n[1]};
            repeat (3) @(negedge ref_clk_i);
            check("enable", tx_enable_o, n != 0);
        end
        for (int i = 0; i < 7; i++)
            commit_buf(i); // buffer 6 has id zero, never picked
        u_host.prep(2, g);
        check("refused", g, 0);
        send(0, 3, 4, 16'h0000, 0);
        send(0, 5, 5, 16'h0000, 0);
        send(0, 5, 1, 16'h0000, 0);
        send(1, 0, 16, 16'h0000, 0);
        send(1, 0, 3, 16'h0000, 0);
        send(1, 0, 3, 16'h0000, 0);
        @(posedge ref_clk_i);
        cycle_start_i <= 1'b1;
        @(posedge ref_clk_i);
        cycle_start_i <= 1'b0;
        wh = '0;
        commit_buf(0);
        send(0, 5, 2, 16'h0000, 1);
        commit_buf(5);
        send(1, 0, 4, 16'h00fc, 0);
        send(1, 0, 4, 16'h00fb, 0);
        send(1, 0, 2, 16'h0000, 0);
        // pair 6 and 7 as double: odd partner inherits transmit config
        @(posedge ref_clk_i);
        cfg_type_i <= 8'h40;
        mtx[7] = 1'b1;
        commit_buf(7);
        send(1, 0, 2, 16'h0000, 0);
        // host clears every event flag
        @(posedge ref_clk_i);
        event_clr_i <= 8'hff;
        @(posedge ref_clk_i);
        event_clr_i <= 8'h00;
        me = '0;
        repeat (3) @(negedge ref_clk_i);
        check("cleared", buffer_event_flag_o, me);
        give_verdict();
    end
    // watchdog well beyond the expected run length
    initial
    begin
        #500000;
        errors++;
        give_verdict();
    end
endmodule
